// *** hw/spr_pkg.sv ***
// Package: constants and types shared by the power and reset management block
package spr_pkg;

	// ----------------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------------
	localparam int unsigned CLK_HZ            = 10_000_000;
	localparam int unsigned CLK_PERIOD_NS     = 100;
	localparam int unsigned MIN_PRESS_MS      = 16;
	// Least press time on the buttons, in cycles
	localparam int unsigned MIN_PRESS_CYC     = (MIN_PRESS_MS * (CLK_HZ / 1000));
	// Width of the carrier reset pulse, in cycles
	localparam int unsigned RESET_PULSE_CYC   = 1000;
	// Cycles that power must stay good before startup
	localparam int unsigned STARTUP_DELAY_CYC = 1000;
	// Tach gate window in cycles (one second)
	localparam int unsigned TACH_GATE_CYC     = CLK_HZ;
	localparam int unsigned TACH_PULSES_PER_REV = 2;
	// Cycles after reset release until the strap synchronisers hold pin values
	localparam logic [1:0]  STRAP_SETTLE_CYC  = 2'h2;

	// ----------------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------------
	localparam logic [7:0]  FAN_DUTY_RST      = 8'hff;
	localparam logic [15:0] FAN_RPM_RST       = 16'h0000;
	localparam logic [1:0]  BOOT_SEL_RST      = 2'h0;

	// Power state of the managed system
	typedef enum logic [1:0] {
		SPR_OFF,
		SPR_WAIT_GOOD,
		SPR_RUN,
		SPR_SUSPEND
	} spr_state_t;

endpackage : spr_pkg

// *** hw/spr_edge_sync.sv ***
// Module: two-flop input synchroniser with falling-edge pulse
module spr_edge_sync
	import spr_pkg::*;
#(
	parameter logic RESET_LEVEL = 1'b1
) (
	input  wire logic i_clk,
	input  wire logic i_resetn,
	input  wire logic i_pin,
	output logic      o_level,
	output logic      o_fall
);

	logic meta_reg;
	logic sync_reg;
	logic prev_reg;

	// ----------------------------------------------------------------------
	// Synchroniser: only the second flop reads the first
	// ----------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			meta_reg <= RESET_LEVEL;
			sync_reg <= RESET_LEVEL;
			prev_reg <= RESET_LEVEL;
		end else begin
			meta_reg <= i_pin;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign o_level = sync_reg;
	assign o_fall  = prev_reg & ~sync_reg;

endmodule : spr_edge_sync

// *** hw/spr_fan_ctrl.sv ***
// Module: fan PWM drive and tachometer speed measurement
module spr_fan_ctrl
	import spr_pkg::*;
#(
	parameter int unsigned GATE_CYC = TACH_GATE_CYC
) (
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	input  wire logic [7:0]  i_duty,
	input  wire logic        i_tach_fall,
	output logic             o_fan_drive_out,
	output logic             o_fan_drive_oe,
	output logic [15:0]      o_fan_rpm
);

	logic [7:0]  pwm_cnt_reg;
	logic [7:0]  pwm_cnt_next;
	logic        pwm_low_reg;
	logic        pwm_low_next;
	logic [31:0] gate_reg;
	logic [31:0] gate_next;
	logic [15:0] pulse_reg;
	logic [15:0] pulse_next;
	logic [15:0] rpm_reg;
	logic [15:0] rpm_next;

	// ----------------------------------------------------------------------
	// PWM and tach next-state logic
	// ----------------------------------------------------------------------
	always_comb begin
		pwm_cnt_next = pwm_cnt_reg + 8'h01;
		// Open drain: pull low for the off part of the period, release otherwise
		pwm_low_next = (pwm_cnt_reg >= i_duty) && (i_duty != 8'hff);
		gate_next    = gate_reg + 32'h1;
		pulse_next   = i_tach_fall ? pulse_reg + 16'h0001 : pulse_reg;
		rpm_next     = rpm_reg;
		if (gate_reg == GATE_CYC - 1) begin
			gate_next  = 32'h0;
			// A fall on the closing cycle opens the next window instead of being lost
			pulse_next = {15'h0, i_tach_fall};
			// Two pulses per turn: per-second count times 60 / 2
			rpm_next   = 16'((32'(pulse_reg) * 60) / TACH_PULSES_PER_REV);
		end
	end

	// ----------------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pwm_cnt_reg <= 8'h00;
			pwm_low_reg <= 1'b0;
			gate_reg    <= 32'h0;
			pulse_reg   <= 16'h0000;
			rpm_reg     <= FAN_RPM_RST;
		end else begin
			pwm_cnt_reg <= pwm_cnt_next;
			pwm_low_reg <= pwm_low_next;
			gate_reg    <= gate_next;
			pulse_reg   <= pulse_next;
			rpm_reg     <= rpm_next;
		end
	end

	assign o_fan_drive_out = 1'b0;
	assign o_fan_drive_oe  = pwm_low_reg;
	assign o_fan_rpm       = rpm_reg;

endmodule : spr_fan_ctrl

// *** hw/spr_power_reset.sv ***
// Module: system power, reset and fan management for the carrier interface
// ----------------------------------------------------------------------------
// Overview of operation
// - A falling edge on the power button makes a power-button event.
// - Power-button events wake from soft-off or suspend, or power a running system down.
// - Reset button is active low, edge triggered; falling edge starts reset.
// - A held-low reset button does not keep the system in reset.
// - Carrier reset driven by button, bad power, low 12 V, watchdog or software.
// - High power-good means good power; startup waits while it is low.
// - Watchdog output signals that a watchdog timeout occurred.
// - Active-low suspend warning asserted on the cycle suspend is entered and held through it; unused in enhanced serial mode.
// - Fan speed set by open-drain PWM output duty cycle.
// - Boot source from two active-low straps; unconnected strap reads deasserted.
// ----------------------------------------------------------------------------
module spr_power_reset
	import spr_pkg::*;
#(
	parameter int unsigned RESET_CYC = RESET_PULSE_CYC,
	parameter int unsigned START_CYC = STARTUP_DELAY_CYC,
	parameter int unsigned GATE_CYC  = TACH_GATE_CYC
) (
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_power_button_n,
	input  wire logic        i_reset_button_n,
	input  wire logic        i_supply_good_in,
	input  wire logic        i_main_twelve_volt_ok,
	input  wire logic        i_watchdog_timeout,
	input  wire logic        i_sw_reset_req,
	input  wire logic        i_suspend_req,
	input  wire logic        i_enhanced_serial_mode,
	input  wire logic        i_fan_speed_pulse_in,
	input  wire logic [7:0]  i_fan_duty,
	input  wire logic        i_boot_select_strap0_n,
	input  wire logic        i_boot_select_strap1_n,
	output logic             o_carrier_reset_out_n,
	output logic             o_watchdog_expired_out,
	output logic             o_suspend_warning_n,
	output logic             o_fan_drive_out,
	output logic             o_fan_drive_oe,
	output logic [15:0]      o_fan_rpm,
	output logic             o_power_button_event,
	output logic             o_system_on,
	output logic             o_soft_off_state,
	output logic [1:0]       o_boot_select
);

	// ----------------------------------------------------------------------
	// Input conditioning
	// ----------------------------------------------------------------------
	logic pwr_lvl;
	logic pwr_fall;
	logic rst_lvl;
	logic rst_fall;
	logic good_lvl;
	logic tach_fall;
	logic v12_lvl;
	logic s0_lvl;
	logic s1_lvl;

	spr_edge_sync #(.RESET_LEVEL(1'b1)) u_sync_pwr (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_pin    (i_power_button_n),
		.o_level  (pwr_lvl),
		.o_fall   (pwr_fall)
	);
	spr_edge_sync #(.RESET_LEVEL(1'b1)) u_sync_rst (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_pin    (i_reset_button_n),
		.o_level  (rst_lvl),
		.o_fall   (rst_fall)
	);
	spr_edge_sync #(.RESET_LEVEL(1'b0)) u_sync_good (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_pin    (i_supply_good_in),
		.o_level  (good_lvl),
		.o_fall   ()
	);
	spr_edge_sync #(.RESET_LEVEL(1'b1)) u_sync_tach (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_pin    (i_fan_speed_pulse_in),
		.o_level  (),
		.o_fall   (tach_fall)
	);
	spr_edge_sync #(.RESET_LEVEL(1'b0)) u_sync_v12 (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_pin    (i_main_twelve_volt_ok),
		.o_level  (v12_lvl),
		.o_fall   ()
	);
	spr_edge_sync #(.RESET_LEVEL(1'b1)) u_sync_s0 (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_pin    (i_boot_select_strap0_n),
		.o_level  (s0_lvl),
		.o_fall   ()
	);
	spr_edge_sync #(.RESET_LEVEL(1'b1)) u_sync_s1 (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_pin    (i_boot_select_strap1_n),
		.o_level  (s1_lvl),
		.o_fall   ()
	);

	// ----------------------------------------------------------------------
	// Power state machine and reset pulse
	// ----------------------------------------------------------------------
	spr_state_t  state_reg;
	spr_state_t  state_next;
	logic [31:0] rst_cnt_reg;
	logic [31:0] rst_cnt_next;
	logic [31:0] start_cnt_reg;
	logic [31:0] start_cnt_next;
	logic        rst_out_n_reg;
	logic        rst_out_n_next;
	logic        wdt_reg;
	logic        wdt_next;
	logic        susw_n_reg;
	logic        susw_n_next;
	logic        pbe_reg;
	logic        pbe_next;
	logic [1:0]  boot_reg;
	logic [1:0]  boot_next;
	logic        boot_taken_reg;
	logic        boot_taken_next;
	logic [1:0]  boot_age_reg;
	logic [1:0]  boot_age_next;
	logic        level_cause;
	logic        pulse_cause;

	// Level causes hold reset for as long as they last; edge causes start a timed pulse
	assign level_cause = ~good_lvl | ~v12_lvl;
	assign pulse_cause = rst_fall | i_watchdog_timeout | i_sw_reset_req;

	always_comb begin
		state_next      = state_reg;
		start_cnt_next  = start_cnt_reg;
		rst_cnt_next    = (rst_cnt_reg != 32'h0) ? rst_cnt_reg - 32'h1 : 32'h0;
		wdt_next        = wdt_reg | i_watchdog_timeout;
		pbe_next        = pwr_fall;
		boot_next       = boot_reg;
		boot_taken_next = boot_taken_reg;
		boot_age_next   = boot_age_reg;
		susw_n_next     = 1'b1;
		// Pulse length is fixed, so a held button cannot extend the reset
		if (pulse_cause) begin
			rst_cnt_next = 32'(RESET_CYC);
		end
		case (state_reg)
			SPR_OFF: begin
				if (pwr_fall) begin
					state_next     = SPR_WAIT_GOOD;
					start_cnt_next = 32'h0;
				end
			end
			SPR_WAIT_GOOD: begin
				// Startup held off while supply is not good
				if (!good_lvl) begin
					start_cnt_next = 32'h0;
				end else if (start_cnt_reg == START_CYC - 1) begin
					state_next = SPR_RUN;
					// Flag clears on startup, but a timeout in this very cycle still sets it
					wdt_next   = i_watchdog_timeout;
				end else begin
					start_cnt_next = start_cnt_reg + 32'h1;
				end
			end
			SPR_RUN: begin
				if (pwr_fall) begin
					state_next = SPR_OFF;
				end else if (i_suspend_req) begin
					state_next = SPR_SUSPEND;
				end
				// Warn bus peripherals from the same cycle that the state enters suspend
				susw_n_next = ~(i_suspend_req & ~i_enhanced_serial_mode);
			end
			SPR_SUSPEND: begin
				susw_n_next = i_enhanced_serial_mode;
				if (pwr_fall) begin
					state_next     = SPR_WAIT_GOOD;
					start_cnt_next = 32'h0;
				end
			end
			default: begin
				state_next = SPR_OFF;
			end
		endcase
		rst_out_n_next = ~(level_cause | pulse_cause | (rst_cnt_next != 32'h0)
			| (state_next != SPR_RUN));
		// Pulled-high straps read 0 when open; the choice follows the synchroniser
		// until it has filled, since the first edges only see its reset level
		if (!boot_taken_reg) begin
			boot_next       = {~s1_lvl, ~s0_lvl};
			if (boot_age_reg == STRAP_SETTLE_CYC) begin
				boot_taken_next = 1'b1;
			end else begin
				boot_age_next = boot_age_reg + 2'h1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_reg      <= SPR_OFF;
			rst_cnt_reg    <= 32'h0;
			start_cnt_reg  <= 32'h0;
			rst_out_n_reg  <= 1'b0;
			wdt_reg        <= 1'b0;
			susw_n_reg     <= 1'b1;
			pbe_reg        <= 1'b0;
			boot_reg       <= BOOT_SEL_RST;
			boot_taken_reg <= 1'b0;
			boot_age_reg   <= 2'h0;
		end else begin
			state_reg      <= state_next;
			rst_cnt_reg    <= rst_cnt_next;
			start_cnt_reg  <= start_cnt_next;
			rst_out_n_reg  <= rst_out_n_next;
			wdt_reg        <= wdt_next;
			susw_n_reg     <= susw_n_next;
			pbe_reg        <= pbe_next;
			boot_reg       <= boot_next;
			boot_taken_reg <= boot_taken_next;
			boot_age_reg   <= boot_age_next;
		end
	end

	// ----------------------------------------------------------------------
	// Fan control
	// ----------------------------------------------------------------------
	spr_fan_ctrl #(.GATE_CYC(GATE_CYC)) u_fan (
		.i_clk           (i_clk),
		.i_resetn        (i_resetn),
		.i_duty          (i_fan_duty),
		.i_tach_fall     (tach_fall),
		.o_fan_drive_out (o_fan_drive_out),
		.o_fan_drive_oe  (o_fan_drive_oe),
		.o_fan_rpm       (o_fan_rpm)
	);

	assign o_carrier_reset_out_n  = rst_out_n_reg;
	assign o_watchdog_expired_out = wdt_reg;
	assign o_suspend_warning_n    = susw_n_reg;
	assign o_power_button_event   = pbe_reg;
	assign o_system_on            = (state_reg == SPR_RUN);
	assign o_soft_off_state       = (state_reg == SPR_OFF);
	assign o_boot_select          = boot_reg;

	// ----------------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	chk_button_event: assert property (pwr_fall |=> o_power_button_event)
		else $error("power button edge gave no event");
	chk_wake_off: assert property (state_reg == SPR_OFF && pwr_fall |=> state_reg == SPR_WAIT_GOOD)
		else $error("power event did not wake from soft off");
	chk_run_down: assert property (state_reg == SPR_RUN && pwr_fall |=> state_reg == SPR_OFF)
		else $error("power event did not power down");
	chk_reset_edge: assert property (rst_fall |=> !o_carrier_reset_out_n)
		else $error("reset button edge gave no reset");
	chk_held_button: assert property (rst_cnt_reg <= 32'(RESET_CYC))
		else $error("reset pulse counter above its length");
	chk_bad_power: assert property (!good_lvl || !v12_lvl |=> !o_carrier_reset_out_n)
		else $error("bad power did not reset carrier");
	chk_hold_start: assert property (state_reg == SPR_WAIT_GOOD && !good_lvl |=> state_reg != SPR_RUN)
		else $error("startup while power not good");
	chk_watchdog_out: assert property (i_watchdog_timeout |=> o_watchdog_expired_out ##0 !o_carrier_reset_out_n)
		else $error("watchdog timeout not signalled");
	chk_suspend_warn: assert property (state_reg == SPR_SUSPEND && !i_enhanced_serial_mode |=> !o_suspend_warning_n)
		else $error("suspend warning missing");
	chk_boot_strap: assert property ($past(boot_taken_reg) |-> o_boot_select == $past(boot_reg))
		else $error("boot selection changed after capture");
	chk_held_level: assert property (!rst_lvl && !pulse_cause && rst_cnt_reg != 32'h0
		|=> rst_cnt_reg == $past(rst_cnt_reg) - 32'h1)
		else $error("held reset button stretched the pulse");
	chk_sw_reset: assert property (i_sw_reset_req |=> !o_carrier_reset_out_n)
		else $error("software request gave no carrier reset");
	chk_event_pulse: assert property (o_power_button_event |=> !o_power_button_event)
		else $error("power button event longer than one cycle");
	chk_serial_quiet: assert property ($past(i_enhanced_serial_mode) |-> o_suspend_warning_n)
		else $error("suspend warning driven in enhanced serial mode");

	cov_power_on: cover property (state_reg == SPR_WAIT_GOOD ##1 state_reg == SPR_RUN);
	cov_suspend: cover property (state_reg == SPR_SUSPEND);
	cov_button_reset: cover property (state_reg == SPR_RUN && rst_fall);
	cov_power_down: cover property (state_reg == SPR_RUN ##1 state_reg == SPR_OFF);
	cov_held_power: cover property (pwr_fall ##1 !pwr_lvl [*8]);

endmodule : spr_power_reset

// *** dv/spr_carrier_model.sv ***
// Carrier board model: buttons, fan tachometer and fan pin pull-up
module spr_carrier_model #(
	parameter int PRESS_CYC = 20
) (
	input  wire logic       i_clk,
	input  wire logic       i_pwr_req,
	input  wire logic       i_rst_req,
	input  wire logic [7:0] i_rev_cyc,
	input  wire logic       i_fan_oe,
	output logic            o_power_button_n,
	output logic            o_reset_button_n,
	output logic            o_tach,
	output logic            o_fan_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	int pcnt = 0;
	int rcnt = 0;
	int tcnt = 0;

	// Presses are stretched to a minimum; shortened from 16 ms to keep runs short
	always @(posedge i_clk) begin
		pcnt <= i_pwr_req ? PRESS_CYC : (pcnt > 0 ? pcnt - 1 : 0);
		rcnt <= i_rst_req ? PRESS_CYC : (rcnt > 0 ? rcnt - 1 : 0);
		tcnt <= (tcnt + 1 >= i_rev_cyc) ? 0 : tcnt + 1;
	end

	// Released buttons go to their pull-ups
	assign o_power_button_n = !(i_pwr_req || pcnt > 0);
	assign o_reset_button_n = !(i_rst_req || rcnt > 0);
	// Two low pulses per turn; a stopped fan leaves the pull-up high
	assign o_tach = (i_rev_cyc == 0) || (tcnt % (i_rev_cyc / 2)) >= (i_rev_cyc / 4);
	// Open-drain pin with the fan's pull-up
	assign o_fan_pin = !i_fan_oe;
endmodule : spr_carrier_model

// *** dv/spr_power_reset_bench.sv ***
// Testbench for the power, reset and fan management block
module spr_power_reset_bench
	import spr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        i_clk = 1'b0;
	logic        i_resetn = 1'b0;
	logic        pwr_req = 1'b0, rst_req = 1'b0, good = 1'b0, v12 = 1'b1;
	logic        wdt = 1'b0, swr = 1'b0, susp = 1'b0, esm = 1'b0;
	logic [7:0]  duty = 8'h80, rev = 8'h00;
	logic [1:0]  strap_n = 2'h1;
	logic        pb_n, rb_n, tach, fan_pin, carrier_n, wdt_out, susp_n, fan_out, fan_oe, pev, sys_on, soft_off;
	logic [15:0] rpm;
	logic [1:0]  boot;
	logic [1:0]  exp_q[$];
	logic [15:0] lfsr = 16'h002a;
	int          n_mismatch = 0;
	int          check_count = 0;

	always #50 i_clk = ~i_clk;

	spr_power_reset #(.RESET_CYC(4), .START_CYC(4), .GATE_CYC(100)) u_spr_power_reset (
		.i_clk(i_clk), .i_resetn(i_resetn), .i_power_button_n(pb_n), .i_reset_button_n(rb_n),
		.i_supply_good_in(good), .i_main_twelve_volt_ok(v12), .i_watchdog_timeout(wdt),
		.i_sw_reset_req(swr), .i_suspend_req(susp), .i_enhanced_serial_mode(esm),
		.i_fan_speed_pulse_in(tach), .i_fan_duty(duty), .i_boot_select_strap0_n(strap_n[0]),
		.i_boot_select_strap1_n(strap_n[1]), .o_carrier_reset_out_n(carrier_n),
		.o_watchdog_expired_out(wdt_out), .o_suspend_warning_n(susp_n), .o_fan_drive_out(fan_out),
		.o_fan_drive_oe(fan_oe), .o_fan_rpm(rpm), .o_power_button_event(pev), .o_system_on(sys_on),
		.o_soft_off_state(soft_off), .o_boot_select(boot));

	spr_carrier_model #(.PRESS_CYC(20)) u_spr_carrier_model (
		.i_clk(i_clk), .i_pwr_req(pwr_req), .i_rst_req(rst_req), .i_rev_cyc(rev), .i_fan_oe(fan_oe),
		.o_power_button_n(pb_n), .o_reset_button_n(rb_n), .o_tach(tach), .o_fan_pin(fan_pin));

	// ------------------------------------------------------------------
	// Compare and helper tasks
	// ------------------------------------------------------------------
	task automatic chk_word(string name, logic [15:0] exp, logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk_word

	task automatic chk_bit(string name, logic exp, logic got);
		chk_word(name, {15'h0, exp}, {15'h0, got});
	endtask : chk_bit

	function automatic logic [15:0] lfsr_next(logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr_next

	task automatic cyc(int n);
		repeat (n) @(posedge i_clk);
	endtask : cyc

	// Press long enough to be seen; the state the event leads to is noted
	task automatic press(logic [1:0] exp);
		exp_q.push_back(exp);
		pwr_req <= 1'b1;
		@(posedge i_clk);
		pwr_req <= 1'b0;
		cyc(30);
	endtask : press

	task automatic final_report();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report

	// Event pulses are matched to the oldest note, read mid-cycle once settled
	always @(negedge i_clk) begin
		if (pev === 1'b1) begin
			if (exp_q.size() == 0) chk_bit("unexpected event", 1'b0, 1'b1);
			else chk_word("state after event", {14'h0, exp_q.pop_front()}, {14'h0, sys_on, soft_off});
		end
	end

	// Cuts a hang short well past the expected run length
	initial begin
		cyc(20000);
		n_mismatch++;
		final_report();
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		int n;
		cyc(7);
		@(negedge i_clk);
		chk_word("reset values", 16'h0024, {9'h0, carrier_n, soft_off, sys_on, wdt_out, susp_n, fan_oe, pev});
		chk_word("rpm reset", 16'h0000, rpm);
		@(posedge i_clk);
		i_resetn <= 1'b1;
		cyc(10);
		chk_word("boot select", 16'h0002, {14'h0, boot});
		chk_bit("fan data", 1'b0, fan_out);
		// Supply kept bad holds the startup back
		press(2'h0);
		cyc(20);
		chk_word("held off", 16'h0000, {14'h0, sys_on, carrier_n});
		good <= 1'b1;
		cyc(12);
		chk_word("started", 16'h0003, {14'h0, sys_on, carrier_n});
		// Software, watchdog, low 12 V and bad power each pull the carrier reset low, then let it go
		for (int k = 0; k < 4; k++) begin
			swr <= (k == 0);
			wdt <= (k == 1);
			v12 <= (k != 2);
			good <= (k != 3);
			@(posedge i_clk);
			swr <= 1'b0;
			wdt <= 1'b0;
			cyc(2);
			@(negedge i_clk);
			chk_bit("reset cause", 1'b0, carrier_n);
			if (k == 1) chk_bit("watchdog flag", 1'b1, wdt_out);
			cyc(8);
			v12 <= 1'b1;
			good <= 1'b1;
			cyc(14);
			@(negedge i_clk);
			chk_bit("reset released", 1'b1, carrier_n);
			@(posedge i_clk);
		end
		// A held reset button gives one pulse only
		rst_req <= 1'b1;
		cyc(4);
		@(negedge i_clk);
		chk_bit("button reset", 1'b0, carrier_n);
		cyc(20);
		chk_bit("held button", 1'b1, carrier_n);
		chk_bit("watchdog sticky", 1'b1, wdt_out);
		rst_req <= 1'b0;
		cyc(30);
		// Suspend with and without the enhanced serial mode, each woken by a press
		for (int k = 0; k < 2; k++) begin
			esm <= (k == 1);
			susp <= 1'b1;
			@(posedge i_clk);
			susp <= 1'b0;
			@(negedge i_clk);
			chk_word("suspend", {14'h0, k == 1, 1'b0}, {14'h0, susp_n, sys_on});
			@(posedge i_clk);
			press(2'h0);
			cyc(12);
			chk_word("resumed", 16'h0003, {14'h0, sys_on, susp_n});
			chk_bit("watchdog cleared", 1'b0, wdt_out);
		end
		esm <= 1'b0;
		press(2'h1);
		// PWM low time over one 256-cycle period, the last duty random
		rev <= 8'h14;
		for (int k = 0; k < 3; k++) begin
			lfsr = lfsr_next(lfsr);
			duty <= (k == 0) ? 8'h40 : (k == 1) ? 8'h00 : (lfsr[7:0] & 8'hfe);
			cyc(260);
			n = 0;
			repeat (256) begin
				@(negedge i_clk);
				n += int'(fan_pin === 1'b0);
			end
			chk_word("fan low cycles", 16'h0100 - {8'h0, duty}, n[15:0]);
		end
		chk_word("fan rpm", 16'h012c, rpm);
		chk_word("events left", 16'h0000, 16'(exp_q.size()));
		final_report();
	end
endmodule : spr_power_reset_bench
